// ===== rtl/dmct_consts.svh
// Overview of operation
// RL1 - Preset high byte at offset 0x6, low byte at offset 0x7.
// RL2 - Host never loads a preset below 0x0002.
// RL3 - Preset bytes are write-only; reads there never return the preset.
// RL4 - Timer square wave period equals twice the preset, in counter clocks.
// RL5 - Idle after reset until a start read at address 1110.
// RL6 - Timer runs continuously; each start restarts a cycle from the preset.
// RL7 - Timer preset rewrite takes effect from the next half-period.
// RL8 - Timer sets ready once per wave cycle; stop read 1111 clears it only.
// RL9 - Pin three carries the timer square wave when selected.
// RL10 - Counter start loads preset, counts down, sets ready at 0x0000.
// RL11 - Counter keeps decrementing past zero, wrapping, until stopped.
// RL12 - Counter pin three high until terminal count, low after; stop restores.
// RL13 - Counter preset applies only at next start; old preset kept.
// RL14 - Host stops the counter before reading both count bytes.
// RL15 - Divide-by-16 source gives maximum divisor of 1,048,575; code reaches 16 x 65535 = 1,048,560.
// RL16 - Counter ready reaches interrupt output only while mask bit 3 is set.
// RL17 - Three-bit field picks mode and clock source; codes 1xx are timer.
// RL18 - Reset leaves block idle, ready clear, pin three high.
`ifndef DMCT_CONSTS_SVH
`define DMCT_CONSTS_SVH
`define DMCT_ADDR_AUX_CTRL    4'h4
`define DMCT_ADDR_INT_MASK    4'h5
`define DMCT_ADDR_PRESET_HIGH 4'h6
`define DMCT_ADDR_PRESET_LOW  4'h7
`define DMCT_ADDR_START       4'he
`define DMCT_ADDR_STOP        4'hf
`define DMCT_MODE_LSB         4
`define DMCT_MODE_MSB         6
`define DMCT_READY_BIT        3
`define DMCT_MODE_RESET       3'h0
`define DMCT_MASK_RESET       8'h00
`define DMCT_PRESET_RESET     16'h0002
`define DMCT_PRESCALE_LAST    4'hf
`endif

// ===== rtl/dmct_pkg.sv
package dmct_pkg;
   // Clock source choices, in the order of the mode field codes
   typedef enum logic [1:0] {
      DMCT_SRC_IP2,
      DMCT_SRC_TXA,
      DMCT_SRC_TXB,
      DMCT_SRC_XTAL
   } dmct_src_t;
   typedef enum {
      DMCT_IDLE,
      DMCT_RUN,
      DMCT_HALT
   } dmct_state_t;
endpackage : dmct_pkg

// ===== rtl/dmct_counter_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "dmct_consts.svh"
module dmct_counter_timer
   import dmct_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   // Clock, reset, enable
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   // Host bus, same clock domain
   input  wire logic [3:0] host_addr,
   input  wire logic [7:0] host_wdata,
   input  wire logic       host_rd,
   input  wire logic       host_wr,
   output logic      [7:0] host_rdata,
   // Counter clock pins
   input  wire logic       external_input_two,
   input  wire logic       transmit_a_unit_clock,
   input  wire logic       transmit_b_unit_clock,
   input  wire logic       crystal_clock_input,
   // Output pin selection and results
   input  wire logic       op3_is_counter,
   output logic            output_pin_three,
   output logic            counter_ready,
   output logic            counter_irq
);

   ////////////////////////////////////////////////////////////////////////////
   logic [2:0]       auxiliary_control;
   logic [7:0]       interrupt_mask;
   logic [CNT_W-1:0] preset;
   logic [CNT_W-1:0] count;
   logic             wave;
   logic             cnt_out;
   logic [3:0]       prescale;
   dmct_state_t      state;
   logic [3:0]       s1;
   logic [3:0]       s2;
   logic [3:0]       s3;
   logic [3:0]       filt;
   logic [3:0]       filt_d;

   ////////////////////////////////////////////////////////////////////////////
   // Pin clocks: three stages, a change counts once stages two and three agree
   // Clock enable low freezes the stages too, so no edge is lost or doubled
   wire logic [3:0] pins = {crystal_clock_input, transmit_b_unit_clock,
                            transmit_a_unit_clock, external_input_two};
   wire logic [3:0] rise;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_sync
         always_ff @(posedge core_clk)
         begin
            if (sys_rst)
            begin
               s1[g]     <= 1'b0;
               s2[g]     <= 1'b0;
               s3[g]     <= 1'b0;
               filt[g]   <= 1'b0;
               filt_d[g] <= 1'b0;
            end
            else if (clk_en)
            begin
               s1[g]     <= pins[g];
               s2[g]     <= s1[g];
               s3[g]     <= s2[g];
               filt[g]   <= (s2[g] == s3[g]) ? s3[g] : filt[g];
               filt_d[g] <= filt[g];
            end
         end
         assign rise[g] = filt[g] & ~filt_d[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Mode field decode
   // A mode change mid-run is not sequenced; stop and restart around it
   wire logic      timer_mode = auxiliary_control[2]; // RL17
   wire dmct_src_t src_sel    = timer_mode ?
      (auxiliary_control[1] ? DMCT_SRC_XTAL : DMCT_SRC_IP2) :
      dmct_src_t'(auxiliary_control[1:0]); // RL17
   wire logic      div16      = timer_mode ? auxiliary_control[0]
                                           : (auxiliary_control[1:0] == 2'b11); // RL17
   wire logic      src_edge   = rise[src_sel];
   // Prescaler only advances while running, so a start gives a clean phase
   wire logic      ct_tick    = (state == DMCT_RUN) & src_edge &
                                (~div16 | (prescale == `DMCT_PRESCALE_LAST)); // RL15

   ////////////////////////////////////////////////////////////////////////////
   // Host access decode
   wire logic do_start  = host_rd & (host_addr == `DMCT_ADDR_START); // RL5
   wire logic do_stop   = host_rd & (host_addr == `DMCT_ADDR_STOP); // RL8
   wire logic wr_aux    = host_wr & (host_addr == `DMCT_ADDR_AUX_CTRL);
   wire logic wr_mask   = host_wr & (host_addr == `DMCT_ADDR_INT_MASK);
   wire logic wr_hi     = host_wr & (host_addr == `DMCT_ADDR_PRESET_HIGH);
   wire logic wr_lo     = host_wr & (host_addr == `DMCT_ADDR_PRESET_LOW);
   wire logic [7:0] status_rd = {4'h0, counter_ready, 3'h0};
   // Count, not preset, answers at the preset offsets
   wire logic [7:0] next_rdata =
      (host_addr == `DMCT_ADDR_INT_MASK)   ? status_rd :
      (host_addr == `DMCT_ADDR_PRESET_HIGH) ? count[15:8] : // RL3
      (host_addr == `DMCT_ADDR_PRESET_LOW)  ? count[7:0] : 8'h00; // RL3

   ////////////////////////////////////////////////////////////////////////////
   // Count engine
   // Timer reloads only at a half-period end or a start, so a rewrite waits for one
   wire logic tc_timer   = timer_mode & ct_tick & (count <= 16'h0001);
   wire logic tc_counter = ~timer_mode & ct_tick & (count == 16'h0001);
   wire logic ready_set  = (tc_timer & ~wave) | tc_counter; // RL8 RL10
   // Next preset word, assembled from the two byte writes
   wire logic [CNT_W-1:0] next_preset = {wr_hi ? host_wdata : preset[15:8],
                                         wr_lo ? host_wdata : preset[7:0]}; // RL1
   wire logic [CNT_W-1:0] next_count =
      do_start ? preset :                       // RL6 RL10 RL13
      tc_timer ? preset :                       // RL4 RL7
      ct_tick  ? count - 16'h0001 : count;      // RL11

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         auxiliary_control <= `DMCT_MODE_RESET;
         interrupt_mask    <= `DMCT_MASK_RESET;
         preset            <= `DMCT_PRESET_RESET;
         host_rdata        <= 8'h00;
      end
      else if (clk_en)
      begin
         if (wr_aux)
            auxiliary_control <= host_wdata[`DMCT_MODE_MSB:`DMCT_MODE_LSB];
         if (wr_mask)
            interrupt_mask <= host_wdata;
         preset <= next_preset; // RL1
         if (host_rd)
            host_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run state: only a start leaves idle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         state <= DMCT_IDLE; // RL18
      else if (clk_en)
      begin
         case (state)
            DMCT_IDLE:
               if (do_start)
                  state <= DMCT_RUN; // RL5
            DMCT_RUN:
               if (do_stop & ~timer_mode)
                  state <= DMCT_HALT; // RL8 RL12
            DMCT_HALT:
               if (do_start)
                  state <= DMCT_RUN; // RL10
            default:
               state <= DMCT_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         count    <= 16'h0000;
         prescale <= 4'h0;
         wave     <= 1'b1;
      end
      else if (clk_en)
      begin
         count <= next_count;
         if (do_start)
            prescale <= 4'h0;
         else if ((state == DMCT_RUN) & src_edge)
            prescale <= prescale + 4'h1; // RL15
         if (do_start)
            wave <= 1'b1; // RL6
         else if (tc_timer)
            wave <= ~wave; // RL4
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ready flag: a set in the same cycle as a stop wins
   wire logic next_ready   = ready_set | (counter_ready & ~do_stop); // RL8
   // Counter output low from terminal count until stop or restart
   wire logic next_cnt_out = tc_counter ? 1'b0 :
                             (do_stop | do_start) ? 1'b1 : cnt_out; // RL12
   // Wave pin follows the toggle in the cycle of the reload, no extra lag
   wire logic next_wave_pin = do_start ? 1'b1 : (tc_timer ? ~wave : wave); // RL4
   wire logic next_pin     = ~op3_is_counter ? 1'b1 :
                             timer_mode ? next_wave_pin : next_cnt_out; // RL9 RL12

   ////////////////////////////////////////////////////////////////////////////
   // Output registers
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         counter_ready    <= 1'b0; // RL18
         cnt_out          <= 1'b1;
         output_pin_three <= 1'b1; // RL18
         counter_irq      <= 1'b0;
      end
      else if (clk_en)
      begin
         counter_ready    <= next_ready;
         cnt_out          <= next_cnt_out;
         output_pin_three <= next_pin;
         counter_irq      <= next_ready & interrupt_mask[`DMCT_READY_BIT]; // RL16
      end
   end

endmodule : dmct_counter_timer
`default_nettype wire

// ===== test/dmct_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dmct_chk (
   // Clock, reset, enable
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       clk_en,
   // Host bus
   input wire logic       host_rd,
   input wire logic       host_wr,
   input wire logic [3:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   // Pin three and status
   input wire logic       op3_is_counter,
   input wire logic       output_pin_three,
   input wire logic       counter_ready,
   input wire logic       counter_irq
);
   logic started;
   logic mask3;
   logic mask_d;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // Helpers track start and mask writes
   always_ff @(posedge core_clk)
      if (sys_rst)
         {started, mask3, mask_d} <= 3'b000;
      else if (clk_en)
         {started, mask3, mask_d} <= {started | (host_rd && host_addr == 4'he),
            (host_wr && host_addr == 4'h5) ? host_wdata[3] : mask3, mask3};
   sequence s_start;
      host_rd && host_addr == 4'he;
   endsequence
   sequence s_stop;
      host_rd && host_addr == 4'hf;
   endsequence
   a_reset_idle: assert property (disable iff (1'b0)
      sys_rst |=> output_pin_three && !counter_ready && !counter_irq && host_rdata == 8'h00)
      else $error("reset state wrong");
   a_idle_start: assert property (!started |-> output_pin_three && !counter_ready)
      else $error("ran before start");
   a_start_high: assert property (s_start ##0 op3_is_counter |=> ##1 output_pin_three)
      else $error("pin low after start");
   a_stop_clear: assert property (s_stop |=> !counter_ready || $changed(output_pin_three))
      else $error("stop left ready set");
   a_status_bits: assert property (host_rd && host_addr == 4'h5 |=>
      host_rdata[7:4] == 4'h0 && host_rdata[2:0] == 3'h0)
      else $error("status bits wrong");
   a_unmapped_zero: assert property (host_rd && (host_addr < 4'h5 ||
      (host_addr > 4'h7 && host_addr < 4'he)) |=> host_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
      else $error("read data moved");
   a_pin_gate: assert property (!op3_is_counter [*2] |-> output_pin_three)
      else $error("pin driven while not selected");
   // Irq registers ready with the mask as it stood before the edge
   a_irq_mask: assert property (counter_irq == (counter_ready && mask_d))
      else $error("irq does not follow ready and mask");
   a_freeze_hold: assert property (!clk_en |=> $stable(output_pin_three) &&
      $stable(counter_ready) && $stable(counter_irq) && $stable(host_rdata))
      else $error("outputs moved while enable low");
endmodule : dmct_chk
bind dmct_counter_timer dmct_chk u_dmct_chk (.core_clk, .sys_rst, .clk_en, .host_rd, .host_wr,
   .host_addr, .host_wdata, .host_rdata, .op3_is_counter, .output_pin_three, .counter_ready,
   .counter_irq);
`default_nettype wire

// ===== test/dmct_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dmct_host_model (
   // Bus to the block
   input wire logic       core_clk,
   input wire logic [7:0] host_rdata,
   output logic     [3:0] host_addr,
   output logic     [7:0] host_wdata,
   output logic           host_rd,
   output logic           host_wr
);
   initial {host_rd, host_wr, host_addr, host_wdata} = 14'h0000;
   // One-cycle strobe; data line inverted after release
   task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge core_clk);
      {host_rd, host_wr, host_addr, host_wdata} <= {r, !r, a, d};
      @(posedge core_clk);
      {host_rd, host_wr, host_wdata} <= {2'b00, ~d};
      @(negedge core_clk);
      q = host_rdata;
   endtask : acc
   task automatic preset(input logic [15:0] p);
      logic [7:0] q;
      if (p < 16'h0002)
         p = 16'h0002;
      acc(1'b0, 4'h6, p[15:8], q);
      acc(1'b0, 4'h7, p[7:0], q);
   endtask : preset
   task automatic count(output logic [15:0] c);
      logic [7:0] q;
      acc(1'b1, 4'hf, 8'h00, q);
      acc(1'b1, 4'h6, 8'h00, c[15:8]);
      acc(1'b1, 4'h7, 8'h00, c[7:0]);
   endtask : count
endmodule : dmct_host_model
`default_nettype wire

// ===== test/dual_mode_counter_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_mode_counter_timer_tb;
   logic        core_clk = 1'b0, sys_rst = 1'b1, src = 1'b0, op3 = 1'b1, en = 1'b1;
   logic [3:0]  host_addr;
   logic [7:0]  host_wdata, host_rdata, q;
   logic        host_rd, host_wr, pin, ready, irq;
   logic [15:0] c;
   int          fail_count = 0, checks = 0, n, m, p;
   always #4 core_clk = ~core_clk;
   // Source pins toggle every four clocks, so ticks come eight clocks apart
   always
   begin
      repeat (4) @(posedge core_clk);
      src <= ~src;
   end
   dmct_counter_timer u_dmct_counter_timer (.core_clk, .sys_rst, .clk_en(en), .host_addr,
      .host_wdata, .host_rd, .host_wr, .host_rdata, .external_input_two(src),
      .transmit_a_unit_clock(src), .transmit_b_unit_clock(src), .crystal_clock_input(src),
      .op3_is_counter(op3), .output_pin_three(pin), .counter_ready(ready), .counter_irq(irq));
   dmct_host_model u_dmct_host_model (.core_clk, .host_rdata, .host_addr, .host_wdata,
      .host_rd, .host_wr);
   ////////////////////////////////////////
   function automatic int cyc(int t);
      return 8 * t;
   endfunction : cyc
   function automatic logic ok(int n, int t);
      return n > cyc(t) - 8 && n <= cyc(t);
   endfunction : ok
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [3:0] a);
      u_dmct_host_model.acc(1'b1, a, 8'h00, q);
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      u_dmct_host_model.acc(1'b0, a, d, q);
   endtask : wr
   task automatic wait_pin(input logic lvl, output int n);
      n = 0;
      while (pin !== lvl && n < 3000)
      begin
         @(negedge core_clk);
         n++;
      end
   endtask : wait_pin
   task automatic period(output int t);
      int a;
      wait_pin(1'b0, a);
      wait_pin(1'b1, a);
      wait_pin(1'b0, a);
      wait_pin(1'b1, t);
      t += a;
   endtask : period
   task automatic test_done();
      $display("checks %0d fails %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h3b08));
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      chk({pin, ready, irq, host_rdata}, 16'h0400);
      p = 2 + $urandom % 8;
      u_dmct_host_model.preset(p[15:0]);
      rd(4'h7);
      chk(q, 8'h00);
      repeat (40) @(negedge core_clk);
      chk({pin, ready}, 2'b10);
      $display("idle test done");
      wr(4'h5, 8'h08);
      wr(4'h4, 8'h40);
      rd(4'he);
      period(n);
      chk(n, cyc(2 * p));
      repeat (2) @(negedge core_clk);
      chk({ready, irq}, 2'b11);
      rd(4'h5);
      chk(q, 8'h08);
      rd(4'hf);
      chk({ready, irq}, 2'b00);
      period(n);
      chk(n, cyc(2 * p));
      u_dmct_host_model.preset(p[15:0] + 16'h0001);
      wait_pin(1'b0, n);
      chk(n > cyc(p) - 8 && n <= cyc(p), 1'b1);
      @(posedge core_clk) op3 <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk(pin, 1'b1);
      @(posedge core_clk) op3 <= 1'b1;
      period(n);
      chk(n, cyc(2 * p + 2));
      $display("timer test done");
      @(posedge core_clk) en <= 1'b0;
      @(negedge core_clk);
      c = {13'h0000, pin, ready, irq};
      repeat (100) @(negedge core_clk);
      chk({pin, ready, irq}, c);
      @(posedge core_clk) en <= 1'b1;
      rd(4'hf);
      wr(4'h4, 8'h00);
      rd(4'he);
      wait_pin(1'b0, n);
      chk({ok(n, p + 1), ready}, 2'b11);
      repeat (cyc(5)) @(negedge core_clk);
      u_dmct_host_model.count(c);
      chk(c[15:8], 8'hff);
      chk({pin, ready}, 2'b10);
      rd(4'he);
      u_dmct_host_model.preset(p[15:0] + 16'h0002);
      wait_pin(1'b0, n);
      chk(ok(n + 4, p + 1), 1'b1);
      $display("counter test done");
      u_dmct_host_model.preset(16'h0002);
      for (m = 0; m < 8; m++)
      begin
         rd(4'hf);
         wr(4'h4, {1'b0, m[2:0], 4'h0});
         rd(4'he);
         for (n = 0; n < 1500 && ready !== 1'b1; n++)
            @(negedge core_clk);
         chk(ready, 1'b1);
      end
      $display("mode test done");
      test_done();
   end
   initial
   begin
      #(8 * 60000);
      fail_count++;
      test_done();
   end
endmodule : dual_mode_counter_timer_tb
`default_nettype wire
